// File: hdl/sar_adc_cfg.svh
// Timing counts and field constants of the serial readout sequencer.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
`define RESULT_WIDTH 16
`define COUNT_WIDTH 6
`define NULL_EDGE 6'h05
`define FIRST_MSB_EDGE 6'h06
`define FIRST_LSB_EDGE 6'h15
`define LAST_REPEAT_EDGE 6'h24
`define DONE_EDGE 6'h25
`endif

// File: hdl/sar_adc_pkg.sv
// Types shared by the serial readout sequencer.
package sar_adc_pkg;
  typedef logic [15:0] result_t;
  typedef logic [5:0] edge_count_t;
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_SAMPLE = 5'b00010,
    ST_CONVERT = 5'b00100,
    ST_REPEAT = 5'b01000,
    ST_IDLE = 5'b10000
  } phase_e;
endpackage

// File: hdl/pin_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  input wire logic reset_value_in,
  output logic sync_out
);
  logic meta_reg;
  logic hold_reg;
  // The flops hold the pin relative to its idle level, so reset loads only constants.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in ^ reset_value_in;
      hold_reg <= meta_reg;
    end
  end
  assign sync_out = hold_reg ^ reset_value_in;
endmodule
`default_nettype wire

// File: hdl/sar_adc_serial_readout.sv
// Serial conversion and readout sequencer of a 16-bit SAR converter.
// Behaviour
// - Select falling starts sampling and a new serial transfer.
// - Input samples during the first 4.5 to 5.0 shift clock periods.
// - After fifth falling shift clock edge, output enables and drives low null bit.
// - Then sixteen result bits follow, most significant first.
// - Output changes on each falling shift clock edge, one bit per period.
// - After the lsb, further clocks resend the other bits lsb first, starting from bit 1.
// - After the repeated msb, the output goes high-impedance.
// - Further shift clocks are ignored while select stays low.
// - New conversion needs select high then low again.
// - Result is two's complement, 7fff to 8000.
// - Each bit goes out as soon as its decision is made.
// - Raising select aborts the conversion and powers down.
// - Power-down on completion and whenever select is high.
// - Select low after completion powers down analog only.
// - Shifted bits belong to the conversion in progress.
`include "sar_adc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_readout
  import sar_adc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic select_n_in,
  input wire logic shift_clock_in,
  input wire logic comparator_in,
  output logic serial_data_out,
  output logic serial_data_oe_n_out,
  output logic sample_window_out,
  output logic conversion_window_out,
  output logic compare_strobe_out,
  output logic [15:0] trial_code_out,
  output logic analog_power_out,
  output logic digital_power_out
);
  logic select_n_sync;
  logic shift_clock_sync;
  logic select_n_prev_reg;
  logic shift_clock_prev_reg;
  phase_e phase_reg;
  phase_e phase_next;
  edge_count_t count_reg;
  result_t result_reg;
  result_t trial_reg;
  logic [3:0] bit_index_reg;

  // Only the second flop of each synchroniser is read here.
  pin_sync select_sync_inst (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(select_n_in),
    .reset_value_in(1'b1),
    .sync_out(select_n_sync)
  );
  pin_sync shift_sync_inst (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(shift_clock_in),
    .reset_value_in(1'b0),
    .sync_out(shift_clock_sync)
  );

  function automatic logic [3:0] bit_position(input edge_count_t count);
    edge_count_t offset;
    offset = count - `FIRST_MSB_EDGE;
    bit_position = offset[3:0];
  endfunction

  // One-hot weight of a result bit, shared by the trial code and the decision.
  function automatic result_t weight(input logic [3:0] index);
    weight = 16'h0001 << index;
  endfunction

  // True for the counts at which the msb-first bits are decided on rising edges and sent on falling edges.
  function automatic logic decision_slot(input edge_count_t count);
    decision_slot = (count >= `NULL_EDGE) && (count < `FIRST_LSB_EDGE);
  endfunction

  // The select register resets high so a low select at reset release counts as a start.
  wire select_fall = select_n_prev_reg & ~select_n_sync;
  wire select_high = select_n_sync;
  wire shift_fall = shift_clock_prev_reg & ~shift_clock_sync;
  wire shift_rise = ~shift_clock_prev_reg & shift_clock_sync;
  // A falling edge seen with count n sends msb-first bit 20 - n, or repeat bit n - 20.
  wire [3:0] msb_index = 4'hf - bit_position(count_reg + 6'h01);
  wire [3:0] lsb_index = bit_position(count_reg - 6'h0e);
  wire in_convert = (phase_reg == ST_CONVERT);
  wire in_repeat = (phase_reg == ST_REPEAT);

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      ST_OFF: begin
        if (select_fall) begin
          phase_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (shift_fall && count_reg == `NULL_EDGE - 6'h01) begin
          phase_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (shift_fall && count_reg == `FIRST_LSB_EDGE) begin
          phase_next = ST_REPEAT;
        end
      end
      ST_REPEAT: begin
        if (shift_fall && count_reg == `LAST_REPEAT_EDGE) begin
          phase_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        phase_next = ST_IDLE;
      end
      default: begin
        phase_next = ST_OFF;
      end
    endcase
    if (select_high) begin
      phase_next = ST_OFF;
    end
  end

  // Edge history resets to each pin's idle level so reset release shows no false edge.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      select_n_prev_reg <= 1'b1;
    end else begin
      select_n_prev_reg <= select_n_sync;
    end
  end

  // The shift clock history starts low, the level at which a frame opens.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_clock_prev_reg <= 1'b0;
    end else begin
      shift_clock_prev_reg <= shift_clock_sync;
    end
  end

  // The phase moves only on detected edges; select high overrides everything.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_reg <= ST_OFF;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Falling edges are counted from select falling; idle edges change nothing.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= 6'h00;
    end else if (select_high || select_fall) begin
      count_reg <= 6'h00;
    end else if (shift_fall && phase_reg != ST_IDLE && phase_reg != ST_OFF) begin
      count_reg <= count_reg + 6'h01;
    end
  end

  // Decisions fall on the rising edges from the null bit up to the one before the lsb goes out.
  wire decide = in_convert && shift_rise && decision_slot(count_reg);
  wire msb_decision = (bit_index_reg == 4'hf);
  wire decision_bit = msb_decision ? ~comparator_in : comparator_in;
  wire [15:0] trial_weight = weight(bit_index_reg);
  // A decision clears the bit on trial and writes the comparator's verdict in its place.
  wire [15:0] decided_code = (result_reg & ~trial_weight) | (decision_bit ? trial_weight : 16'h0000);
  wire last_decision = (bit_index_reg == 4'h0);
  wire [15:0] next_trial = last_decision ? decided_code : (decided_code | weight(bit_index_reg - 4'h1));

  // The line serves msb-first bits until the lsb leaves, then the lsb-first repeat.
  wire msb_first_slot = in_convert && decision_slot(count_reg);
  wire next_bit = msb_first_slot ? result_reg[msb_index] : result_reg[lsb_index];
  // The null bit is the first bit driven, at the falling edge that ends sampling.
  wire null_slot = shift_fall && (phase_reg == ST_SAMPLE);
  // Outside the conversion and its repeat the line is released.
  wire out_disabled = (phase_next == ST_OFF) || (phase_next == ST_SAMPLE) || (phase_next == ST_IDLE);
  wire sampling_next = (phase_next == ST_SAMPLE);
  wire converting_next = (phase_next == ST_CONVERT);

  // Only the decided bits are kept; the word is never buffered ahead of the line.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_reg <= 16'h0000;
    end else if (select_fall) begin
      result_reg <= 16'h0000;
    end else if (decide) begin
      // The msb weight is negative in two's complement, so its decision is inverted.
      result_reg <= decided_code;
    end
  end

  // The bit index walks down once per decision and is rearmed by each select fall.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_index_reg <= 4'hf;
    end else if (select_fall) begin
      bit_index_reg <= 4'hf;
    end else if (decide) begin
      bit_index_reg <= bit_index_reg - 4'h1;
    end
  end

  // Trial code presented to the capacitor array: decided bits plus the bit now on trial.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trial_reg <= 16'h0000;
    end else if (select_high) begin
      trial_reg <= 16'h0000;
    end else if (select_fall) begin
      trial_reg <= weight(4'hf);
    end else if (decide) begin
      trial_reg <= next_trial;
    end
  end

  // Window and analog power levels follow the next phase so they move with the state, not a cycle later.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sample_window_out <= 1'b0;
    end else begin
      sample_window_out <= sampling_next;
    end
  end

  // The conversion window spans the null bit and the msb-first run.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conversion_window_out <= 1'b0;
    end else begin
      conversion_window_out <= converting_next;
    end
  end

  // One pulse per decision; a slow shift clock never stretches it.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      compare_strobe_out <= 1'b0;
    end else begin
      compare_strobe_out <= decide;
    end
  end

  // The trial code leaves through a register so the array never sees a decode glitch.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trial_code_out <= 16'h0000;
    end else begin
      trial_code_out <= trial_reg;
    end
  end

  // The analog section is off outside sampling and conversion, so the repeat costs only logic power.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      analog_power_out <= 1'b0;
    end else begin
      analog_power_out <= sampling_next || converting_next;
    end
  end

  // Digital power follows select alone: a finished frame with select low keeps the logic alive.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      digital_power_out <= 1'b0;
    end else begin
      digital_power_out <= !select_high;
    end
  end

  // The line is released before the null bit, after the repeated msb and whenever select is high.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_data_oe_n_out <= 1'b1;
    end else if (out_disabled) begin
      serial_data_oe_n_out <= 1'b1;
    end else if (shift_fall) begin
      serial_data_oe_n_out <= 1'b0;
    end
  end

  // A new bit appears one clock after a detected falling edge and stands until the next one.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_data_out <= 1'b0;
    end else if (out_disabled) begin
      serial_data_out <= 1'b0;
    end else if (null_slot) begin
      serial_data_out <= 1'b0;
    end else if (shift_fall) begin
      serial_data_out <= next_bit;
    end
  end
endmodule
`default_nettype wire

// File: tb/readout_sva.sv
// Port assertions of the serial readout sequencer.
`timescale 1ns/10ps
`default_nettype none
module readout_sva (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic select_n_in,
  input wire logic shift_clock_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n_out,
  input wire logic conversion_window_out,
  input wire logic compare_strobe_out,
  input wire logic analog_power_out,
  input wire logic digital_power_out,
  input wire logic sample_window_out,
  input wire logic [15:0] trial_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_hiz; select_n_in [*8] |-> serial_data_oe_n_out && !conversion_window_out; endproperty
  a_hiz: assert property (p_hiz) else $error("output driven with select high");
  property p_off; select_n_in [*8] |-> !digital_power_out && !analog_power_out; endproperty
  a_off: assert property (p_off) else $error("powered with select high");
  property p_on; !select_n_in [*8] |-> digital_power_out; endproperty
  a_on: assert property (p_on) else $error("digital off with select low");
  property p_hold; (!select_n_in && shift_clock_in) [*8] |-> $stable(serial_data_out) && $stable(serial_data_oe_n_out); endproperty
  a_hold: assert property (p_hold) else $error("output moved without a falling edge");
  property p_en; $fell(serial_data_oe_n_out) |-> !serial_data_out && !shift_clock_in; endproperty
  a_en: assert property (p_en) else $error("enable without low null bit");
  property p_win; $rose(conversion_window_out) |-> ##[0:1] !serial_data_oe_n_out; endproperty
  a_win: assert property (p_win) else $error("window without enabled output");
  property p_stb; compare_strobe_out |-> conversion_window_out && shift_clock_in ##1 !compare_strobe_out; endproperty
  a_stb: assert property (p_stb) else $error("stray decision strobe");
  property p_ana; !select_n_in && $rose(serial_data_oe_n_out) |-> !analog_power_out && digital_power_out; endproperty
  a_ana: assert property (p_ana) else $error("analog still powered after completion");
  property p_smp; sample_window_out |-> serial_data_oe_n_out && analog_power_out && !conversion_window_out; endproperty
  a_smp: assert property (p_smp) else $error("sampling with output driven");
  property p_trial; select_n_in [*8] |-> trial_code_out == 16'h0000; endproperty
  a_trial: assert property (p_trial) else $error("trial code kept with select high");
  c_done: cover property (!select_n_in && $rose(serial_data_oe_n_out));
  c_conv: cover property ($rose(conversion_window_out));
  c_abort: cover property ($rose(select_n_in) && !serial_data_oe_n_out);
endmodule
bind sar_adc_serial_readout readout_sva chk (.clk_in, .reset_n_in, .select_n_in, .shift_clock_in, .serial_data_out,
  .serial_data_oe_n_out, .conversion_window_out, .compare_strobe_out, .analog_power_out, .digital_power_out,
  .sample_window_out, .trial_code_out);
`default_nettype wire

// File: tb/host_model.sv
// Host controller model that frames conversions and samples the serial line.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic oe_n_in,
  output logic select_n_out,
  output logic shift_clock_out
);
  logic [1:0] seen [0:40];
  initial {select_n_out, shift_clock_out} = 2'b10;
  // The clock stands low outside frames, so select always falls with it low.
  task automatic frame(input int n);
    select_n_out = 1'b0;
    for (int k = 0; k <= n; k++) begin
      repeat (16) @(negedge clk_in);
      shift_clock_out = 1'b1;
      seen[k] = {oe_n_in, line_in};
      repeat (16) @(negedge clk_in);
      shift_clock_out = 1'b0;
    end
    select_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the serial readout sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  import sar_adc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic comp = 1'b0;
  logic rnd = 1'b0;
  logic sel_n, sck, data, oe_n, ana, dig;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  result_t got;
  always #2.5 clk_in = ~clk_in;
  sar_adc_serial_readout dut (.clk_in, .reset_n_in, .select_n_in(sel_n), .shift_clock_in(sck), .comparator_in(comp),
    .serial_data_out(data), .serial_data_oe_n_out(oe_n), .sample_window_out(), .conversion_window_out(),
    .compare_strobe_out(), .trial_code_out(), .analog_power_out(ana), .digital_power_out(dig));
  // A released line reads high, the inverse of the data bit that is cleared on release, so a stale value never passes.
  host_model host (.clk_in, .line_in(oe_n ? ~data : data), .oe_n_in(oe_n), .select_n_out(sel_n), .shift_clock_out(sck));
  always @(negedge clk_in) begin
    if (rnd) comp <= 1'($urandom);
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check_frame(input int n, input bit known, input result_t exp);
    for (int k = 0; k <= n; k++) begin
      if (k < 5 || k > 36) `CHK("oe_n", 1'b1, host.seen[k][1])
      else `CHK("oe_n", 1'b0, host.seen[k][1])
      if (k == 5) `CHK("null", 1'b0, host.seen[k][0])
      if (k > 5 && k < 22) got[21 - k] = host.seen[k][0];
      if (k > 21 && k < 37) `CHK("repeat", got[k - 21], host.seen[k][0])
    end
    if (known) `CHK("result", exp, got)
    repeat (8) @(negedge clk_in);
    `CHK("idle", 3'b100, {oe_n, ana, dig})
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(84));
    repeat (5) @(negedge clk_in);
    reset_n_in = 1'b1;
    // Tests 0 and 1 hold the decision fixed to reach both full-scale codes; test 4 cuts the frame short.
    for (int t = 0; t < 6; t++) begin
      int n;
      n = (t == 4) ? 6 + $urandom % 16 : 40;
      rnd = t > 1;
      comp = t[0];
      repeat (8) @(negedge clk_in);
      host.frame(n);
      check_frame(n, t < 2, t[0] ? 16'h7fff : 16'h8000);
      $display("test %0d done", t);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
